/* File: src/i2c_serial_channel_core.sv */
// Two-wire serial channel core: master/slave byte shifter with address match
`timescale 1ns/1ps
module i2c_serial_channel_core
  import i2c_serial_pkg::*;
(
  // Clock, reset, enable
  input  wire logic     sys_clk_i,
  input  wire logic     reset_i,
  input  wire logic     clk_en_i,
  // Register port
  input  wire reg_req_t reg_req_i,
  output logic [7:0]    rdata_o,
  // Bus pins
  input  wire bus_in_t  pins_i,
  output bus_out_t      pins_o,
  // Status
  output logic          transfer_done_o,
  output logic          address_match_o
);
  // ==========================================================================
  // Pin synchronisers
  logic [2:0] pin_raw;
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  assign pin_raw = {pins_i.scl, pins_i.sda_a, pins_i.sda_b};

  for (genvar g = 0; g < 3; g++) begin : g_sync
    always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
        sync1_q[g] <= 1'b1;
        sync2_q[g] <= 1'b1;
      end else if (clk_en_i) begin
        sync1_q[g] <= pin_raw[g];
        sync2_q[g] <= sync1_q[g];
      end
    end
  end

  // ==========================================================================
  // Core state
  xfer_state_t state_q, state_d;
  logic [7:0]  shreg_q, shreg_d, sva_q, sva_d, mode_q, mode_d, rdata_q, rdata_d;
  logic [2:0]  ctrl_q, ctrl_d;
  logic [1:0]  wsel_q, wsel_d;
  logic [3:0]  cnt_q, cnt_d;
  logic [10:0] div_q, div_d;
  logic        gen_low_q, gen_low_d, out_q, out_d, hold_q, hold_d, wait_q, wait_d;
  logic        first_q, first_d, done_q, done_d, start_q, start_d, stop_q, stop_d;
  logic        match_q, match_d, scl_prev_q, sda_prev_q;
  logic        scl_low_q, scl_low_d, sda_low_q, sda_low_d;
  logic        en, wake, master, scl_s, sda_s, scl_rise, scl_fall;
  logic        start_edge, stop_edge, active, done_set;
  logic [3:0]  nbits;
  logic [7:0]  shift_in;

  assign en         = mode_q[MODE_EN];
  assign wake       = mode_q[MODE_WAKE];
  assign master     = mode_q[MODE_MASTER];
  assign scl_s      = sync2_q[2];
  assign sda_s      = mode_q[MODE_PINSEL] ? sync2_q[0] : sync2_q[1];
  assign scl_rise   = scl_s & ~scl_prev_q;
  assign scl_fall   = ~scl_s & scl_prev_q;
  assign start_edge = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign stop_edge  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
  assign nbits      = wsel_q[WAIT_NINE] ? BITS_NINE : BITS_EIGHT;
  assign shift_in   = {shreg_q[6:0], sda_s};
  // In slave mode, wake-up listens without a shift register write
  assign active     = (state_q == ST_SHIFT) || (wake && en && !master);

  always_comb begin
    state_d   = state_q;
    shreg_d   = shreg_q;
    sva_d     = sva_q;
    mode_d    = mode_q;
    ctrl_d    = ctrl_q;
    wsel_d    = wsel_q;
    cnt_d     = cnt_q;
    div_d     = div_q;
    gen_low_d = gen_low_q;
    out_d     = out_q;
    hold_d    = hold_q;
    wait_d    = wait_q;
    first_d   = first_q;
    done_d    = done_q;
    start_d   = start_q;
    stop_d    = stop_q;
    done_set  = 1'b0;
    rdata_d   = 8'h00;
    // Register reads
    if (reg_req_i.rd) begin
      case (reg_req_i.addr)
        ADDR_SHIFT:  rdata_d = shreg_q;
        ADDR_MODE:   rdata_d = mode_q | {7'h00, match_q};
        ADDR_CTRL:   rdata_d = {ctrl_q[2], 3'h0, ctrl_q[1], ctrl_q[0], 2'h0};
        ADDR_STATUS: rdata_d = {3'h0, state_q != ST_IDLE, scl_s & en, stop_q, start_q, done_q};
        ADDR_SLAVE:  rdata_d = sva_q;
        ADDR_WAIT:   rdata_d = {6'h00, wsel_q};
        default:     rdata_d = 8'h00;
      endcase
    end
    // Register writes
    if (reg_req_i.wr) begin
      case (reg_req_i.addr)
        ADDR_SHIFT: begin
          shreg_d = reg_req_i.wdata;
          if (en && state_q == ST_IDLE) begin
            state_d = ST_ARMED;
            wait_d  = 1'b0;
          end
        end
        ADDR_MODE:  mode_d = reg_req_i.wdata & MODE_MASK;
        ADDR_CTRL: begin
          ctrl_d = {reg_req_i.wdata[CTRL_BUSY], reg_req_i.wdata[CTRL_CLK_LEVEL], reg_req_i.wdata[CTRL_STOP_SEL]};
          if (reg_req_i.wdata[CTRL_START_TRIG]) begin
            hold_d  = 1'b1;
            start_d = 1'b1;
          end
          if (reg_req_i.wdata[CTRL_STOP_TRIG]) begin
            hold_d  = 1'b0;
            stop_d  = 1'b1;
            start_d = 1'b0;
          end
        end
        ADDR_STATUS: if (reg_req_i.wdata[STAT_DONE]) done_d = 1'b0;
        ADDR_SLAVE: sva_d = reg_req_i.wdata;
        ADDR_WAIT:  wsel_d = reg_req_i.wdata[1:0];
        default:    ;
      endcase
    end
    // Conditions seen on the bus
    if (start_edge) begin
      start_d = 1'b1;
      stop_d  = 1'b0;
      cnt_d   = 4'h0;
      first_d = 1'b1;
    end
    if (stop_edge) begin
      stop_d  = 1'b1;
      start_d = 1'b0;
      if (ctrl_q[0]) done_set = 1'b1;
    end
    // Shifting
    if (active && scl_rise) begin
      if (cnt_q <= LAST_DATA) shreg_d = shift_in;
      cnt_d = cnt_q + 4'h1;
      if (cnt_q == LAST_DATA && first_q) begin
        first_d = 1'b0;
        if (wake && shift_in == sva_q) done_set = 1'b1;
      end
      if (state_q == ST_SHIFT && cnt_q + 4'h1 == nbits) begin
        if (!wake) done_set = 1'b1;
        if (!master) state_d = ST_TAIL;
      end
    end
    if (state_q == ST_SHIFT && scl_fall) out_d = (cnt_q <= LAST_DATA) ? shreg_q[7] : 1'b1;
    case (state_q)
      ST_IDLE: ;
      ST_ARMED: begin
        if (master || !scl_s) begin
          state_d   = ST_SHIFT;
          out_d     = shreg_q[7];
          cnt_d     = 4'h0;
          div_d     = 11'h000;
          gen_low_d = 1'b1;
          hold_d    = 1'b0;
        end
      end
      ST_SHIFT: begin
        if (master) begin
          div_d = div_q + 11'h001;
          if (gen_low_q) begin
            if (div_q == HALF_LAST) begin
              gen_low_d = 1'b0;
              div_d     = 11'h000;
            end
          end else if (!scl_s) begin
            div_d = 11'h000;
          end else if (div_q == HALF_LAST) begin
            div_d = 11'h000;
            if (cnt_q == nbits) state_d = ST_IDLE;
            else gen_low_d = 1'b1;
          end
        end
      end
      ST_TAIL: begin
        if (scl_fall) begin
          state_d = ST_IDLE;
          if (wsel_q[WAIT_HOLD]) wait_d = 1'b1;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (!en) begin
      state_d = ST_IDLE;
      wait_d  = 1'b0;
    end
    if (done_set) done_d = 1'b1;
    // Open-drain drive: only pull low or release
    if (!en) scl_low_d = 1'b0;
    else if (!master) scl_low_d = wait_q;
    else if (state_q == ST_SHIFT) scl_low_d = gen_low_q;
    else scl_low_d = !ctrl_q[1];
    sda_low_d = en && (hold_q || (state_q == ST_SHIFT && !wake && !out_q));
  end

  assign match_d = (shreg_q == sva_q);

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      state_q    <= ST_IDLE;
      shreg_q    <= BYTE_RESET;
      sva_q      <= BYTE_RESET;
      mode_q     <= BYTE_RESET;
      rdata_q    <= BYTE_RESET;
      ctrl_q     <= 3'h0;
      wsel_q     <= WAIT_RESET;
      cnt_q      <= 4'h0;
      div_q      <= 11'h000;
      gen_low_q  <= 1'b0;
      out_q      <= 1'b1;
      hold_q     <= 1'b0;
      wait_q     <= 1'b0;
      first_q    <= 1'b0;
      done_q     <= 1'b0;
      start_q    <= 1'b0;
      stop_q     <= 1'b0;
      match_q    <= 1'b0;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      scl_low_q  <= 1'b0;
      sda_low_q  <= 1'b0;
    end else if (clk_en_i) begin
      state_q    <= state_d;
      shreg_q    <= shreg_d;
      sva_q      <= sva_d;
      mode_q     <= mode_d;
      rdata_q    <= rdata_d;
      ctrl_q     <= ctrl_d;
      wsel_q     <= wsel_d;
      cnt_q      <= cnt_d;
      div_q      <= div_d;
      gen_low_q  <= gen_low_d;
      out_q      <= out_d;
      hold_q     <= hold_d;
      wait_q     <= wait_d;
      first_q    <= first_d;
      done_q     <= done_d;
      start_q    <= start_d;
      stop_q     <= stop_d;
      match_q    <= match_d;
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
      scl_low_q  <= scl_low_d;
      sda_low_q  <= sda_low_d;
    end
  end

  // ==========================================================================
  // Outputs
  assign rdata_o           = rdata_q;
  assign transfer_done_o   = done_q;
  assign address_match_o   = match_q;
  assign pins_o.scl_o      = 1'b0;
  assign pins_o.scl_oe_n   = ~scl_low_q;
  assign pins_o.sda_a_o    = 1'b0;
  assign pins_o.sda_a_oe_n = ~(sda_low_q & ~mode_q[MODE_PINSEL]);
  assign pins_o.sda_b_o    = 1'b0;
  assign pins_o.sda_b_oe_n = ~(sda_low_q & mode_q[MODE_PINSEL]);

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i || !clk_en_i);

  sequence shift_write_s;
    reg_req_i.wr && reg_req_i.addr == ADDR_SHIFT && state_q == ST_IDLE;
  endsequence
  sequence stop_trig_s;
    reg_req_i.wr && reg_req_i.addr == ADDR_CTRL && reg_req_i.wdata[CTRL_STOP_TRIG];
  endsequence

  xfer_start_a: assert property (shift_write_s ##0 en |=> state_q == ST_ARMED)
    else $error("enabled shift write did not arm transfer");
  no_start_off_a: assert property (shift_write_s ##0 !en |=> state_q == ST_IDLE)
    else $error("disabled shift write armed transfer");
  done_count_a: assert property (state_q == ST_SHIFT && !wake && scl_rise && cnt_q == nbits - 4'h1
                                 |=> done_q)
    else $error("done flag not set at last clock");
  wake_done_a: assert property (wake && active && scl_rise && cnt_q == LAST_DATA && first_q
                                && shift_in == sva_q |=> done_q)
    else $error("done flag not set on address match");
  wake_release_a: assert property (wake && !hold_q |=> pins_o.sda_a_oe_n && pins_o.sda_b_oe_n)
    else $error("data driven during wake-up reception");
  slave_clock_a: assert property (en && !master && !wait_q |=> pins_o.scl_oe_n && !pins_o.scl_o)
    else $error("slave drove clock without wait");
  clock_level_a: assert property (en && master && state_q == ST_IDLE && !ctrl_q[1] |=> !pins_o.scl_oe_n)
    else $error("clock not pulled low at level zero");
  stretch_a: assert property (master && state_q == ST_SHIFT && !gen_low_q && !scl_s |=> div_q == 11'h000)
    else $error("master advanced while clock held low");
  stop_flags_a: assert property (stop_trig_s ##0 !start_edge |=> stop_q && !start_q && !hold_q)
    else $error("stop trigger flags wrong");
  shift_in_a: assert property (active && scl_rise && cnt_q <= LAST_DATA |=> shreg_q[0] == $past(sda_s))
    else $error("data not sampled on clock rise");
  tail_wait_a: assert property (state_q == ST_TAIL && scl_fall && wsel_q[WAIT_HOLD] && en
                                |=> wait_q ##1 !pins_o.scl_oe_n)
    else $error("slave wait not applied");
endmodule // i2c_serial_channel_core

/* File: src/i2c_serial_pkg.sv */
// Constants, types and register map of the two-wire serial channel
package i2c_serial_pkg;
  // ==========================================================================
  // Register offsets
  localparam logic [2:0] ADDR_SHIFT  = 3'h0;
  localparam logic [2:0] ADDR_MODE   = 3'h1;
  localparam logic [2:0] ADDR_CTRL   = 3'h2;
  localparam logic [2:0] ADDR_STATUS = 3'h3;
  localparam logic [2:0] ADDR_SLAVE  = 3'h4;
  localparam logic [2:0] ADDR_WAIT   = 3'h5;
  // ==========================================================================
  // Field positions
  localparam int MODE_EN         = 7;
  localparam int MODE_WAKE       = 5;
  localparam int MODE_MASTER     = 4;
  localparam int MODE_PINSEL     = 1;
  localparam int MODE_MATCH      = 0;
  localparam int CTRL_BUSY       = 7;
  localparam int CTRL_CLK_LEVEL  = 3;
  localparam int CTRL_STOP_SEL   = 2;
  localparam int CTRL_START_TRIG = 1;
  localparam int CTRL_STOP_TRIG  = 0;
  localparam int STAT_DONE       = 0;
  localparam int STAT_START      = 1;
  localparam int STAT_STOP       = 2;
  localparam int STAT_SCL        = 3;
  localparam int STAT_BUSY       = 4;
  localparam int WAIT_NINE       = 0;
  localparam int WAIT_HOLD       = 1;
  // ==========================================================================
  // Reset values, masks and counts
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] MODE_MASK  = 8'hb2;
  localparam logic [1:0] WAIT_RESET = 2'h3;
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE  = 4'h9;
  localparam logic [3:0] LAST_DATA  = 4'h7;
  // ==========================================================================
  // Timing: half period of the generated bus clock
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned SCL_HALF_NS   = 5000;
  localparam int unsigned SCL_HALF_CYC  = (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [10:0] HALF_LAST     = 11'(SCL_HALF_CYC - 1);
  // ==========================================================================
  // Types
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_ARMED = 4'b0010,
    ST_SHIFT = 4'b0100,
    ST_TAIL  = 4'b1000
  } xfer_state_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic scl;
    logic sda_a;
    logic sda_b;
  } bus_in_t;

  typedef struct packed {
    logic scl_o;
    logic scl_oe_n;
    logic sda_a_o;
    logic sda_a_oe_n;
    logic sda_b_o;
    logic sda_b_oe_n;
  } bus_out_t;
endpackage

/* File: test/i2c_far_end_model.sv */
// Far-side model of the two-wire bus: bit capture, fault injection and a simple master
`timescale 1ns/1ps
module i2c_far_end_model (
  // Wire levels
  input  wire logic scl_i,
  input  wire logic sda_i,
  // Pull-downs, high pulls the wire low
  output logic      scl_pull_o,
  output logic      sda_pull_o
);
  logic [7:0] bits;
  int         rises;
  int         err_idx;
  int         stretch_at;
  realtime    rise_t;
  realtime    min_high;

  initial begin
    scl_pull_o = 1'b0;
    sda_pull_o = 1'b0;
    clear(-1, -1);
  end

  // ==========================================================================
  // Capture of bits sent by the channel
  always @(posedge scl_i) begin
    bits   <= {bits[6:0], sda_i};
    rises  <= rises + 1;
    rise_t <= $realtime;
  end

  // Data error and one long clock stretch while the channel sends
  always @(negedge scl_i) begin
    if ($realtime - rise_t < min_high) begin
      min_high = $realtime - rise_t;
    end
    if (err_idx >= 0) begin
      sda_pull_o <= (rises == err_idx);
    end
    if (rises == stretch_at) begin
      scl_pull_o = 1'b1;
      #8000;
      scl_pull_o = 1'b0;
    end
  end

  task automatic clear(input int e, input int s);
    rises      = 0;
    err_idx    = e;
    stretch_at = s;
    min_high   = 1.0e9;
    sda_pull_o = 1'b0;
  endtask

  // ==========================================================================
  // Master side: 64 ns bus clock, waits while the line is held low
  task automatic put_bit(input logic b);
    sda_pull_o = ~b;
    #16;
    scl_pull_o = 1'b0;
    wait (scl_i === 1'b1);
    #32;
    scl_pull_o = 1'b1;
    #16;
  endtask

  task automatic start_cond();
    sda_pull_o = 1'b0;
    #16;
    scl_pull_o = 1'b0;
    #32;
    sda_pull_o = 1'b1;
    #32;
    scl_pull_o = 1'b1;
    #16;
  endtask

  task automatic stop_cond();
    sda_pull_o = 1'b1;
    #16;
    scl_pull_o = 1'b0;
    #32;
    sda_pull_o = 1'b0;
    #32;
  endtask

  task automatic send_frame(input logic [6:0] addr7, input logic rw);
    for (int i = 6; i >= 0; i--) begin
      put_bit(addr7[i]);
    end
    put_bit(rw);
    put_bit(1'b1);
  endtask

  // Let the clock wire go once the channel has had time to hold it
  task automatic let_go();
    #40;
    scl_pull_o = 1'b0;
  endtask
endmodule // i2c_far_end_model

/* File: test/i2c_serial_channel_core_tb.sv */
// Self-checking bench of the two-wire serial channel core
`timescale 1ns/1ps
module i2c_serial_channel_core_tb
  import i2c_serial_pkg::*;
();
  logic       sys_clk_i;
  logic       reset_i;
  reg_req_t   req;
  logic [7:0] rdata;
  bus_in_t    pins_in;
  bus_out_t   pins_out;
  logic       done;
  logic       match;
  logic       scl_pull;
  logic       sda_pull;
  logic       scl_w;
  logic       sda_w;
  logic       watch;
  logic       sda_pulled;
  int         mismatches;
  int         n_compared;
  int         cycles;

  // Open-drain wires with pull-ups
  assign scl_w   = pins_out.scl_oe_n & ~scl_pull;
  assign sda_w   = pins_out.sda_a_oe_n & ~sda_pull;
  assign pins_in = '{scl: scl_w, sda_a: sda_w, sda_b: pins_out.sda_b_oe_n};

  i2c_serial_channel_core dut_u (
    .sys_clk_i       (sys_clk_i),
    .reset_i         (reset_i),
    .clk_en_i        (1'b1),
    .reg_req_i       (req),
    .rdata_o         (rdata),
    .pins_i          (pins_in),
    .pins_o          (pins_out),
    .transfer_done_o (done),
    .address_match_o (match)
  );

  i2c_far_end_model far_u (
    .scl_i      (scl_w),
    .sda_i      (sda_w),
    .scl_pull_o (scl_pull),
    .sda_pull_o (sda_pull)
  );

  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  // ==========================================================================
  // Checking and register access
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("FAIL t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk_i);
    req <= '0;
  endtask

  task automatic rchk(input logic [2:0] a, input logic [7:0] e);
    @(posedge sys_clk_i);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk_i);
    req <= '0;
    #1;
    check(rdata, e);
  endtask

  task automatic wait_done(input int limit);
    int n;
    n = 0;
    while (done !== 1'b1 && n < limit) begin
      @(posedge sys_clk_i);
      n++;
    end
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    rchk(ADDR_WAIT, {6'h00, WAIT_RESET});
    rchk(ADDR_MODE, 8'h01);
    rchk(3'h6, 8'h00);
    check({7'h00, done}, 8'h00);
    $display("test reset finished");
  endtask

  task automatic t_disabled();
    wr(ADDR_MODE, 8'h10);
    wr(ADDR_SHIFT, 8'h3c);
    wr(ADDR_MODE, 8'h90);
    far_u.clear(-1, -1);
    repeat (2200) @(posedge sys_clk_i);
    rchk(ADDR_STATUS, 8'h00);
    check(8'(far_u.rises), 8'h00);
    $display("test late enable finished");
  endtask

  task automatic t_master();
    wr(ADDR_CTRL, 8'h08);
    repeat (10) @(posedge sys_clk_i);
    check({7'h00, scl_w}, 8'h01);
    wr(ADDR_CTRL, 8'h0a);
    repeat (10) @(posedge sys_clk_i);
    check({6'h00, scl_w, sda_w}, 8'h02);
    rchk(ADDR_STATUS, 8'h0a);
    wr(ADDR_CTRL, 8'h00);
    repeat (10) @(posedge sys_clk_i);
    check({7'h00, scl_w}, 8'h00);
    wr(ADDR_SLAVE, 8'ha5);
    wr(ADDR_WAIT, 8'h00);
    far_u.clear(-1, 3);
    wr(ADDR_SHIFT, 8'ha5);
    wait_done(20000);
    check({7'h00, done}, 8'h01);
    check(8'(far_u.rises), 8'h08);
    check(far_u.bits, 8'ha5);
    repeat (1100) @(posedge sys_clk_i);
    check(8'(far_u.rises), 8'h08);
    rchk(ADDR_SHIFT, 8'ha5);
    check({7'h00, match}, 8'h01);
    check({7'h00, far_u.min_high >= 4990.0}, 8'h01);
    $display("test master send finished");
  endtask

  task automatic t_error();
    wr(ADDR_STATUS, 8'h01);
    wr(ADDR_SLAVE, 8'hff);
    wr(ADDR_WAIT, 8'h01);
    far_u.clear(2, -1);
    wr(ADDR_SHIFT, 8'hff);
    wait_done(25000);
    check(8'(far_u.rises), 8'h09);
    repeat (1100) @(posedge sys_clk_i);
    rchk(ADDR_SHIFT, 8'hdf);
    check({7'h00, match}, 8'h00);
    wr(ADDR_CTRL, 8'h02);
    wr(ADDR_CTRL, 8'h08);
    wr(ADDR_CTRL, 8'h09);
    repeat (10) @(posedge sys_clk_i);
    check({6'h00, scl_w, sda_w}, 8'h03);
    rchk(ADDR_STATUS, 8'h0d);
    $display("test send error finished");
  endtask

  task automatic t_wakeup();
    wr(ADDR_MODE, 8'ha0);
    wr(ADDR_CTRL, 8'h04);
    wr(ADDR_SLAVE, 8'h5a);
    wr(ADDR_WAIT, 8'h01);
    wr(ADDR_STATUS, 8'h01);
    far_u.clear(-1, -1);
    watch = 1'b1;
    far_u.start_cond();
    far_u.send_frame(7'h2d, 1'b0);
    repeat (10) @(posedge sys_clk_i);
    check({7'h00, done}, 8'h01);
    check({7'h00, match}, 8'h01);
    wr(ADDR_STATUS, 8'h01);
    far_u.start_cond();
    far_u.send_frame(7'h33, 1'b0);
    repeat (10) @(posedge sys_clk_i);
    check({7'h00, done}, 8'h00);
    far_u.stop_cond();
    repeat (10) @(posedge sys_clk_i);
    check({7'h00, done}, 8'h01);
    watch = 1'b0;
    check({7'h00, sda_pulled}, 8'h00);
    $display("test wake-up finished");
  endtask

  task automatic t_slave_rx();
    wr(ADDR_MODE, 8'h80);
    wr(ADDR_CTRL, 8'h80);
    wr(ADDR_WAIT, 8'h03);
    wr(ADDR_STATUS, 8'h01);
    watch = 1'b1;
    wr(ADDR_SHIFT, 8'hff);
    far_u.start_cond();
    far_u.send_frame(7'h2d, 1'b1);
    far_u.let_go();
    repeat (10) @(posedge sys_clk_i);
    watch = 1'b0;
    check({7'h00, done}, 8'h01);
    check({7'h00, sda_pulled}, 8'h00);
    check({7'h00, scl_w}, 8'h00);
    rchk(ADDR_SHIFT, 8'h5b);
    wr(ADDR_SHIFT, 8'hff);
    repeat (10) @(posedge sys_clk_i);
    check({7'h00, scl_w}, 8'h01);
    rchk(ADDR_STATUS, 8'h1b);
    $display("test slave receive finished");
  endtask

  // ==========================================================================
  // Watchers, hang limit and main sequence
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (watch && pins_out.sda_a_oe_n !== 1'b1) begin
      sda_pulled <= 1'b1;
    end
    if (cycles == 80000) begin
      mismatches = mismatches + 1;
      give_verdict();
    end
  end

  initial begin
    reset_i    = 1'b1;
    req        = '0;
    watch      = 1'b0;
    sda_pulled = 1'b0;
    mismatches = 0;
    n_compared = 0;
    cycles     = 0;
    repeat (2) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    t_reset();
    t_disabled();
    t_master();
    t_error();
    t_wakeup();
    t_slave_rx();
    give_verdict();
  end
endmodule // i2c_serial_channel_core_tb
